// File: rtl/mmp_pkg.sv
`default_nettype none
package mmp_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  localparam int RST_PULSE_NS  = 1000;  // least low time that counts as reset
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_NS       = 2000;  // reset initialisation interval
  localparam int INIT_CYC      = (INIT_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------------
  // two-wire bus and address map
  // ----------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h50;  // bus address of the module
  localparam logic [7:0] UPPER_BASE = 8'h80;  // first upper-region byte
  localparam logic [7:0] OFS_STATUS = 8'h02;  // status byte, bit 0 not-ready
  localparam logic [7:0] OFS_FLAGS  = 8'h08;  // latched flags, clear on read
  localparam logic [7:0] OFS_BANK   = 8'h7e;  // bank select byte
  localparam logic [7:0] OFS_PAGE   = 8'h7f;  // page select byte
  localparam logic [7:0] OFS_RO_TOP = 8'h0d;  // lower bytes up to here read-only
  localparam logic [7:0] PAGE_RST   = 8'h00;
  localparam logic [7:0] BANK_RST   = 8'h00;

  // pages that exist
  localparam logic [7:0] PG_ID    = 8'h00;
  localparam logic [7:0] PG_ADV   = 8'h01;
  localparam logic [7:0] PG_THR   = 8'h02;
  localparam logic [7:0] PG_USER  = 8'h03;
  localparam logic [7:0] PG_LANE0 = 8'h10;
  localparam logic [7:0] PG_LANE1 = 8'h11;

  // memory slots, 128 bytes each
  localparam logic [2:0] SLOT_LOWER = 3'h0;
  localparam logic [2:0] SLOT_ID    = 3'h1;
  localparam logic [2:0] SLOT_ADV   = 3'h2;
  localparam logic [2:0] SLOT_THR   = 3'h3;
  localparam logic [2:0] SLOT_USER  = 3'h4;
  localparam logic [2:0] SLOT_LANE0 = 3'h5;
  localparam logic [2:0] SLOT_LANE1 = 3'h6;
  localparam logic [2:0] SLOT_NONE  = 3'h7;
  localparam int         MEM_DEPTH  = 896;

  // flag bits
  localparam int FLAG_DONE  = 0;  // reset complete
  localparam int FLAG_FAULT = 1;  // operational fault

  // ----------------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_AACK = 7'h04,
    ST_WR   = 7'h08,
    ST_WACK = 7'h10,
    ST_RD   = 7'h20,
    ST_RACK = 7'h40
  } mmp_state_t;

endpackage
`default_nettype wire

// File: rtl/mmp_mem.sv
`default_nettype none
// ------------------------------------------------------------------------
// byte memory, registered read
// ------------------------------------------------------------------------
module mmp_mem #(
  parameter int DW    = 8,
  parameter int AW    = 10,
  parameter int DEPTH = 896
) (
  input  wire logic          mclk,   // core clock
  input  wire logic          clk_en, // freezes the memory when low
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] waddr,  // write address
  input  wire logic [DW-1:0] wdata,  // write data
  input  wire logic [AW-1:0] raddr,  // read address
  output logic      [DW-1:0] rdata   // read data, one cycle after raddr
);

  logic [DW-1:0] mem_ff [DEPTH];

  // contents are not reset: they survive a module reset
  always_ff @(posedge mclk)
  begin
    if (clk_en && we && (int'(waddr) < DEPTH))
    begin
      mem_ff[waddr] <= wdata;
    end
  end

  // out-of-range reads return zero
  always_ff @(posedge mclk)
  begin
    if (clk_en)
    begin
      rdata <= (int'(raddr) < DEPTH) ? mem_ff[raddr] : '0;
    end
  end

endmodule
`default_nettype wire

// File: rtl/mmp_top.sv
`default_nettype none
module mmp_top #(
  parameter int INIT_CYCLES = mmp_pkg::INIT_CYC,
  parameter int RST_CYCLES  = mmp_pkg::RST_PULSE_CYC
) (
  input  wire logic mclk,                // core clock, 250 MHz
  input  wire logic sys_rst,             // synchronous reset, power-up
  input  wire logic clk_en,              // freezes all state when low
  input  wire logic module_select_pin_n, // select pin, low selects
  input  wire logic module_reset_n,      // reset pin, low resets
  input  wire logic low_power_request,   // low-power pin
  input  wire logic scl,                 // bus clock pin
  input  wire logic sda_in,              // bus data pin level
  input  wire logic fault_event,         // core fault pulse, same clock
  output logic      sda_out,             // bus data drive value (0)
  output logic      sda_oe,              // bus data pulled low when high
  output logic      interrupt_out_n,     // interrupt drive value (0)
  output logic      interrupt_out_oe,    // interrupt pulled low when high
  output logic      presence_n,          // presence, always low
  output logic      low_power_state      // reduced-power state active
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NSYNC = 5;
  // reset levels: select and reset idle high as if pulled up
  localparam logic [NSYNC-1:0] SYNC_RST = 5'h1e;
  logic [NSYNC-1:0] pin_vec;
  logic [NSYNC-1:0] meta_ff;
  logic [NSYNC-1:0] sync_ff;
  assign pin_vec = {scl, sda_in, module_select_pin_n, module_reset_n, low_power_request};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          meta_ff[gi] <= SYNC_RST[gi];
          sync_ff[gi] <= SYNC_RST[gi];
        end
        else if (clk_en)
        begin
          meta_ff[gi] <= pin_vec[gi];
          sync_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  logic scl_s;
  logic sda_s;
  logic module_select_n;
  logic rst_n_s;
  logic lp_s;
  assign {scl_s, sda_s, module_select_n, rst_n_s, lp_s} = sync_ff;

  // delayed copies for edge detection
  logic scl_d_ff;
  logic sda_d_ff;
  logic rst_n_d_ff;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      rst_n_d_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      scl_d_ff   <= scl_s;
      sda_d_ff   <= sda_s;
      rst_n_d_ff <= rst_n_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic rst_rise;
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign rst_rise  = rst_n_s & ~rst_n_d_ff;

  // ----------------------------------------------------------------------
  // reset pulse and initialisation
  // ----------------------------------------------------------------------
  logic [15:0] low_cnt_ff;
  logic [15:0] init_cnt_ff;
  logic        init_busy_ff;
  logic        long_rel;
  // short glitches on the reset pin start no initialisation, only a full pulse counts
  assign long_rel = rst_rise && (low_cnt_ff >= 16'(RST_CYCLES));

  // saturating count of the low time
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      low_cnt_ff <= 16'h0000;
    else if (clk_en)
    begin
      if (rst_n_s)
        low_cnt_ff <= 16'h0000;
      else if (low_cnt_ff != 16'hffff)
        low_cnt_ff <= low_cnt_ff + 16'h0001;
    end
  end

  // busy from power-up or from release of a long pulse
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      init_busy_ff <= 1'b1;
      init_cnt_ff  <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (long_rel)
      begin
        init_busy_ff <= 1'b1;
        init_cnt_ff  <= 16'h0000;
      end
      else if (init_busy_ff)
      begin
        if (init_cnt_ff == 16'(INIT_CYCLES - 1))
          init_busy_ff <= 1'b0;
        init_cnt_ff <= init_cnt_ff + 16'h0001;
      end
    end
  end

  logic init_done;
  logic not_ready;
  logic in_reset;
  assign init_done = init_busy_ff && (init_cnt_ff == 16'(INIT_CYCLES - 1));
  assign not_ready = init_busy_ff;
  assign in_reset  = ~rst_n_s;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // upper half maps one page; banked pages only exist in bank 0
  function automatic logic [2:0] map_slot(input logic [7:0] ofs,
                                          input logic [7:0] page,
                                          input logic [7:0] bank);
    logic [2:0] s;
    s = mmp_pkg::SLOT_NONE;
    if (ofs < mmp_pkg::UPPER_BASE)
      s = mmp_pkg::SLOT_LOWER;
    else
    begin
      case (page)
        mmp_pkg::PG_ID:    s = mmp_pkg::SLOT_ID;
        mmp_pkg::PG_ADV:   s = mmp_pkg::SLOT_ADV;
        mmp_pkg::PG_THR:   s = mmp_pkg::SLOT_THR;
        mmp_pkg::PG_USER:  s = mmp_pkg::SLOT_USER;
        mmp_pkg::PG_LANE0: s = (bank == 8'h00) ? mmp_pkg::SLOT_LANE0 : mmp_pkg::SLOT_NONE;
        mmp_pkg::PG_LANE1: s = (bank == 8'h00) ? mmp_pkg::SLOT_LANE1 : mmp_pkg::SLOT_NONE;
        default:           s = mmp_pkg::SLOT_NONE;
      endcase
    end
    return s;
  endfunction

  // static pages and status bytes never take host data
  function automatic logic slot_writable(input logic [2:0] s, input logic [7:0] ofs);
    case (s)
      mmp_pkg::SLOT_LOWER: return ofs > mmp_pkg::OFS_RO_TOP;
      mmp_pkg::SLOT_USER:  return 1'b1;
      mmp_pkg::SLOT_LANE0: return 1'b1;
      mmp_pkg::SLOT_LANE1: return 1'b1;
      default:             return 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------------
  mmp_pkg::mmp_state_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic [7:0] page_ff;
  logic [7:0] bank_ff;
  logic [1:0] flags_ff;
  logic       rw_ff;
  logic       first_ff;
  logic       nack_ff;
  logic [7:0] mem_rdata;
  logic [7:0] nxt_tx;
  logic [2:0] rd_slot;
  logic [2:0] wr_slot;
  logic       byte_in;
  logic       load_tx;
  logic       mem_we;
  logic       bus_off;

  assign rd_slot = map_slot(ptr_ff, page_ff, bank_ff);
  assign wr_slot = map_slot(ptr_ff, page_ff, bank_ff);
  assign byte_in = (state_ff == mmp_pkg::ST_WR) && scl_fall && (bit_cnt_ff == 4'h8);
  assign load_tx = scl_fall && (((state_ff == mmp_pkg::ST_AACK) && rw_ff) ||
                                ((state_ff == mmp_pkg::ST_RACK) && !nack_ff));
  assign mem_we  = byte_in && !first_ff && slot_writable(wr_slot, ptr_ff) &&
                   (ptr_ff != mmp_pkg::OFS_PAGE) && (ptr_ff != mmp_pkg::OFS_BANK);
  // deselected or held in reset: the bus is not watched at all
  assign bus_off = module_select_n | in_reset;

  // read data for the byte at the pointer
  always_comb
  begin
    nxt_tx = mem_rdata;
    if (rd_slot == mmp_pkg::SLOT_NONE)
      nxt_tx = 8'h00;
    else if (ptr_ff == mmp_pkg::OFS_STATUS)
      nxt_tx = {7'h00, not_ready};
    else if (ptr_ff == mmp_pkg::OFS_FLAGS)
      nxt_tx = {6'h00, flags_ff};
    else if (ptr_ff == mmp_pkg::OFS_BANK)
      nxt_tx = bank_ff;
    else if (ptr_ff == mmp_pkg::OFS_PAGE)
      nxt_tx = page_ff;
  end

  // bit sequencing; data line only pulled low, never driven high
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_ff   <= mmp_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff   <= 8'h00;
      tx_ff      <= 8'h00;
      rw_ff      <= 1'b0;
      first_ff   <= 1'b0;
      nack_ff    <= 1'b0;
      sda_oe     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (bus_off || bus_stop)
      begin
        state_ff <= mmp_pkg::ST_IDLE;
        sda_oe   <= 1'b0;
      end
      else if (bus_start)
      begin
        state_ff   <= mmp_pkg::ST_ADDR;
        bit_cnt_ff <= 4'h0;
        sda_oe     <= 1'b0;
      end
      else
      begin
        case (state_ff)
          mmp_pkg::ST_ADDR, mmp_pkg::ST_WR:
          begin
            if (scl_rise)
            begin
              shift_ff   <= {shift_ff[6:0], sda_s};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
            else if (scl_fall && bit_cnt_ff == 4'h8)
            begin
              bit_cnt_ff <= 4'h0;
              if (state_ff == mmp_pkg::ST_WR)
              begin
                state_ff <= mmp_pkg::ST_WACK;
                sda_oe   <= 1'b1;
                first_ff <= 1'b0;
              end
              else if (shift_ff[7:1] == mmp_pkg::DEV_ADDR)
              begin
                state_ff <= mmp_pkg::ST_AACK;
                sda_oe   <= 1'b1;
                rw_ff    <= shift_ff[0];
              end
              else
                state_ff <= mmp_pkg::ST_IDLE;
            end
          end
          mmp_pkg::ST_AACK, mmp_pkg::ST_RACK:
          begin
            if (scl_rise && state_ff == mmp_pkg::ST_RACK)
              nack_ff <= sda_s;
            else if (load_tx)
            begin
              state_ff   <= mmp_pkg::ST_RD;
              tx_ff      <= nxt_tx;
              sda_oe     <= ~nxt_tx[7];
              bit_cnt_ff <= 4'h0;
            end
            else if (scl_fall && state_ff == mmp_pkg::ST_AACK)
            begin
              state_ff <= mmp_pkg::ST_WR;
              sda_oe   <= 1'b0;
              first_ff <= 1'b1;
            end
            else if (scl_fall)
            begin
              state_ff <= mmp_pkg::ST_IDLE;
              sda_oe   <= 1'b0;
            end
          end
          mmp_pkg::ST_WACK:
          begin
            if (scl_fall)
            begin
              state_ff <= mmp_pkg::ST_WR;
              sda_oe   <= 1'b0;
            end
          end
          mmp_pkg::ST_RD:
          begin
            if (scl_rise)
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            else if (scl_fall && bit_cnt_ff == 4'h8)
            begin
              state_ff   <= mmp_pkg::ST_RACK;
              bit_cnt_ff <= 4'h0;
              sda_oe     <= 1'b0;
            end
            else if (scl_fall)
            begin
              tx_ff  <= {tx_ff[6:0], 1'b0};
              sda_oe <= ~tx_ff[6];
            end
          end
          default: state_ff <= mmp_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // pointer, page and bank select
  // ----------------------------------------------------------------------
  // a long reset pulse restores the select bytes to their defaults
  always_ff @(posedge mclk)
  begin
    if (sys_rst || (clk_en && long_rel))
    begin
      ptr_ff  <= 8'h00;
      page_ff <= mmp_pkg::PAGE_RST;
      bank_ff <= mmp_pkg::BANK_RST;
    end
    else if (clk_en && !bus_off)
    begin
      if (byte_in && first_ff)
        ptr_ff <= shift_ff;
      else if (byte_in || load_tx)
        ptr_ff <= ptr_ff + 8'h01;
      if (byte_in && !first_ff && ptr_ff == mmp_pkg::OFS_PAGE)
        page_ff <= shift_ff;
      if (byte_in && !first_ff && ptr_ff == mmp_pkg::OFS_BANK)
        bank_ff <= shift_ff;
    end
  end

  // ----------------------------------------------------------------------
  // flags and pins
  // ----------------------------------------------------------------------
  // a read of the flag byte clears it, but a new event in that cycle wins
  logic [1:0] flag_set;
  logic       flag_rd;
  assign flag_set = {fault_event, init_done};
  assign flag_rd  = load_tx && !bus_off && (ptr_ff == mmp_pkg::OFS_FLAGS);

  always_ff @(posedge mclk)
  begin
    if (sys_rst || (clk_en && long_rel))
      flags_ff <= 2'h0;
    else if (clk_en)
      flags_ff <= flag_set | (flag_rd ? 2'h0 : flags_ff);
  end

  // pins: presence tied low, interrupt and data only ever pulled low
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sda_out          <= 1'b0;
      interrupt_out_n  <= 1'b0;
      interrupt_out_oe <= 1'b0;
      presence_n       <= 1'b0;
      low_power_state  <= 1'b0;
    end
    else if (clk_en)
    begin
      interrupt_out_oe <= |flags_ff;
      low_power_state  <= lp_s;
    end
  end

  // ----------------------------------------------------------------------
  // memory
  // ----------------------------------------------------------------------
  mmp_mem #(.DW(8), .AW(10), .DEPTH(mmp_pkg::MEM_DEPTH)) u_mem (
    .mclk   (mclk),
    .clk_en (clk_en),
    .we     (mem_we),
    .waddr  ({wr_slot, ptr_ff[6:0]}),
    .wdata  (shift_ff),
    .raddr  ({rd_slot, ptr_ff[6:0]}),
    .rdata  (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk iff clk_en);
  endclocking
  default disable iff (sys_rst);

  sequence long_release_s;
    rst_rise && (low_cnt_ff >= 16'(RST_CYCLES));
  endsequence
  sequence init_end_s;
    init_busy_ff && (init_cnt_ff == 16'(INIT_CYCLES - 1));
  endsequence

  desel_quiet_a: assert property (module_select_n |=> !sda_oe)
    else $error("data line pulled while deselected");
  addr_ack_a: assert property ((state_ff == mmp_pkg::ST_ADDR) && scl_fall && !bus_off &&
    !bus_start && !bus_stop && bit_cnt_ff == 4'h8 && shift_ff[7:1] == mmp_pkg::DEV_ADDR
    |=> sda_oe && state_ff == mmp_pkg::ST_AACK)
    else $error("own address not acknowledged");
  reset_restore_a: assert property (long_release_s |=> init_busy_ff &&
    page_ff == mmp_pkg::PAGE_RST && bank_ff == mmp_pkg::BANK_RST && flags_ff == 2'h0)
    else $error("long reset did not restore defaults");
  init_end_a: assert property (init_end_s ##0 !long_rel |=> !init_busy_ff &&
    flags_ff[mmp_pkg::FLAG_DONE] ##1 interrupt_out_oe)
    else $error("reset completion not posted");
  power_up_a: assert property ($fell(sys_rst) |-> init_busy_ff && init_cnt_ff == 16'h0000)
    else $error("no initialisation after power-up");
  lp_follow_a: assert property (lp_s |=> low_power_state)
    else $error("low-power request not followed");
  int_hold_a: assert property (flags_ff != 2'h0 |=> interrupt_out_oe)
    else $error("interrupt released with flags set");
  presence_low_a: assert property (!presence_n && !interrupt_out_n)
    else $error("presence not grounded");
  static_write_a: assert property (mem_we |-> wr_slot != mmp_pkg::SLOT_ID &&
    wr_slot != mmp_pkg::SLOT_ADV && wr_slot != mmp_pkg::SLOT_THR)
    else $error("write reached a static page");
  page_sel_a: assert property (byte_in && !first_ff && !bus_off && !long_rel &&
    ptr_ff == mmp_pkg::OFS_PAGE |=> page_ff == $past(shift_ff))
    else $error("page select byte not taken");

endmodule
`default_nettype wire

// File: bench/mmp_host.sv
`default_nettype none
// ----------------------------------------------------------------------
// two-wire bus master standing for the host board
// ----------------------------------------------------------------------
module mmp_host (
  input  wire logic mclk,   // core clock
  input  wire logic sda,    // resolved data wire
  output logic      scl,    // bus clock, stands high outside frames
  output logic      sda_low // host pulls data low while high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  // quarter of the 48 ns bus period
  task automatic q();
    repeat (3) @(posedge mclk);
  endtask
  // start also serves as repeated start, scl is low on entry then
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  // data set while scl low, sampled mid-high: safe against sync latency
  task automatic bit_io(input logic b, output logic r);
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // last byte is answered with nack so the device lets go of the bus
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// File: bench/mmp_top_tb_top.sv
`default_nettype none
module mmp_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, sys_rst = 1'b1, sel_n = 1'b1, rst_n = 1'b1;
  logic lp = 1'b0, fault = 1'b0, scl, sda_low, sda_oe, irq_oe, pres_n, lp_st, sda_o, irq_n;
  logic [7:0] d;
  logic ack;
  int num_errors = 0;
  int comparisons = 0;
  wire sda = ~(sda_low | sda_oe); // pulled up unless someone pulls low
  always #2 mclk = ~mclk;
  mmp_top #(.INIT_CYCLES(20), .RST_CYCLES(10)) u_mmp_top (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .module_select_pin_n(sel_n),
    .module_reset_n(rst_n), .low_power_request(lp), .scl(scl), .sda_in(sda),
    .fault_event(fault), .sda_out(sda_o), .sda_oe(sda_oe), .interrupt_out_n(irq_n),
    .interrupt_out_oe(irq_oe), .presence_n(pres_n), .low_power_state(lp_st));
  mmp_host u_mmp_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask
  // bounded wait, a miss ends the run
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq_oe !== 1'b1; i++) @(posedge mclk);
    check("irq", irq_oe, 1'b1);
    if (irq_oe !== 1'b1) wrap_up();
  endtask
  task automatic wr(input logic [7:0] off, dat, input logic exp_ack);
    logic a;
    u_mmp_host.start();
    u_mmp_host.put_byte({mmp_pkg::DEV_ADDR, 1'b0}, a);
    u_mmp_host.put_byte(off, ack);
    u_mmp_host.put_byte(dat, ack);
    u_mmp_host.stop();
    check("ack", a, exp_ack);
  endtask
  task automatic rd(input logic [7:0] off, output logic [7:0] dat);
    u_mmp_host.start();
    u_mmp_host.put_byte({mmp_pkg::DEV_ADDR, 1'b0}, ack);
    u_mmp_host.put_byte(off, ack);
    u_mmp_host.start();
    u_mmp_host.put_byte({mmp_pkg::DEV_ADDR, 1'b1}, ack);
    u_mmp_host.get_byte(1'b1, dat);
    u_mmp_host.stop();
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_power_up();
    wait_irq();
    rd(mmp_pkg::OFS_STATUS, d);
    check("not_ready", d[0], 1'b0);
    check("presence", pres_n, 1'b0);
    check("sda_level", sda_o, 1'b0);
    check("irq_level", irq_n, 1'b0);
    rd(mmp_pkg::OFS_FLAGS, d);
    check("done_flag", d[mmp_pkg::FLAG_DONE], 1'b1);
    repeat (4) @(posedge mclk);
    check("irq_clear", irq_oe, 1'b0);
  endtask
  task automatic t_paging();
    wr(mmp_pkg::OFS_PAGE, mmp_pkg::PG_USER, 1'b1);
    wr(8'h80, 8'ha5, 1'b1);
    wr(8'h10, 8'h3c, 1'b1);
    rd(mmp_pkg::OFS_PAGE, d);
    check("page", d, mmp_pkg::PG_USER);
    wr(mmp_pkg::OFS_PAGE, mmp_pkg::PG_ID, 1'b1);
    wr(8'h80, 8'h5a, 1'b1);
    rd(8'h80, d);
    // static pages hold no loaded content, so an unknown read must not fail here
    check("static_wr", d === 8'h5a, 1'b0);
    rd(8'h10, d);
    check("lower_vis", d, 8'h3c);
    wr(mmp_pkg::OFS_PAGE, mmp_pkg::PG_USER, 1'b1);
    rd(8'h80, d);
    check("user_rw", d, 8'ha5);
    wr(mmp_pkg::OFS_PAGE, mmp_pkg::PG_LANE0, 1'b1);
    wr(8'h80, 8'h66, 1'b1);
    rd(8'h80, d);
    check("lane_pg", d, 8'h66);
    wr(mmp_pkg::OFS_BANK, 8'h01, 1'b1);
    rd(mmp_pkg::OFS_BANK, d);
    check("bank_set", d, 8'h01);
    rd(8'h80, d);
    check("bank_sel", d, 8'h00);
    wr(mmp_pkg::OFS_BANK, mmp_pkg::BANK_RST, 1'b1);
    rd(mmp_pkg::OFS_BANK, d);
    check("bank", d, mmp_pkg::BANK_RST);
  endtask
  // a known byte first, so the ignored write has something to disturb
  task automatic t_select();
    wr(8'h11, 8'h22, 1'b1);
    sel_n <= 1'b1;
    wr(8'h11, 8'h77, 1'b0);
    sel_n <= 1'b0;
    rd(8'h11, d);
    check("ignored", d, 8'h22);
  endtask
  task automatic t_fault_lp();
    fault <= 1'b1;
    @(posedge mclk);
    fault <= 1'b0;
    lp <= 1'b1;
    wait_irq();
    rd(mmp_pkg::OFS_FLAGS, d);
    check("fault_flag", d[mmp_pkg::FLAG_FAULT], 1'b1);
    check("low_power", lp_st, 1'b1);
    lp <= 1'b0;
  endtask
  task automatic t_pin_reset();
    rst_n <= 1'b0;
    repeat (14) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    check("irq_in_init", irq_oe, 1'b0);
    wait_irq();
    rd(mmp_pkg::OFS_PAGE, d);
    check("page_dflt", d, mmp_pkg::PAGE_RST);
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    sel_n <= 1'b0;
    t_power_up();
    t_paging();
    t_select();
    t_fault_lp();
    t_pin_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
